// ==== src/pbw_pkg.sv ====
package pbw_pkg;

    // ****************************************************************
    // Power states
    // ****************************************************************
    typedef enum logic [2:0] {
        PBW_S0 = 3'b000,
        PBW_S3 = 3'b001,
        PBW_S4 = 3'b010,
        PBW_S5 = 3'b011
    } pbw_state_t;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned SHORT_PRESS_S = 4;
    localparam int unsigned LONG_PRESS_S  = 6;
    localparam int unsigned DEBOUNCE_MS   = 20;
    localparam int unsigned SHORT_CYC     = SHORT_PRESS_S * CLK_HZ;
    localparam int unsigned LONG_CYC      = LONG_PRESS_S * CLK_HZ;
    localparam int unsigned DEB_CYC       = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W         = 26;

    // ****************************************************************
    // Wake sources
    // ****************************************************************
    localparam int unsigned SRC_N     = 6;
    localparam int unsigned SRC_RTC   = 0;
    localparam int unsigned SRC_NET   = 1;
    localparam int unsigned SRC_USB   = 2;
    localparam int unsigned SRC_PCIE  = 3;
    localparam int unsigned SRC_IR    = 4;
    localparam int unsigned SRC_RADIO = 5;
    localparam logic [5:0] DEEP_MASK  = 6'h14;
    localparam logic [5:0] ACL_MASK   = 6'h14;
    localparam logic [5:0] OPT_MASK   = 6'h04;
    localparam logic [5:0] NET_MASK   = 6'h02;
    localparam logic [5:0] NEVER_MASK = 6'h20;
    localparam logic [5:0] DISP_MASK  = 6'h0B;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_CMD   = 8'h04;
    localparam logic [7:0] REG_WEN   = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam logic [7:0] REG_ISTAT = 8'h10;
    localparam logic [7:0] REG_IMASK = 8'h14;
    localparam int unsigned CTRL_DEEP = 0;
    localparam int unsigned CTRL_USB45 = 1;
    localparam int unsigned CTRL_DISP = 2;
    localparam int unsigned IRQ_N     = 3;
    localparam int unsigned IRQ_SLEEP = 0;
    localparam int unsigned IRQ_FORCE = 1;
    localparam int unsigned IRQ_WAKE  = 2;
    localparam logic [5:0] WEN_RST    = 6'h1F;

endpackage : pbw_pkg

// ==== src/pbw_press_timer.sv ====
`timescale 1ns/1ps
module pbw_press_timer #(
    parameter int unsigned DEB  = pbw_pkg::DEB_CYC,
    parameter int unsigned SHRT = pbw_pkg::SHORT_CYC,
    parameter int unsigned LNG  = pbw_pkg::LONG_CYC
) (
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    input  wire logic i_sw_n,
    output logic      o_short,
    output logic      o_long
);
    import pbw_pkg::*;

    logic             s1_r;
    logic             s2_r;
    logic             stable_r;
    logic [CNT_W-1:0] deb_r;
    logic [CNT_W-1:0] hold_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= ~i_sw_n;
            s2_r <= s1_r;
        end
    end

    // ****************************************************************
    // Debounce: the level must hold for DEB cycles to be believed.
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            deb_r    <= '0;
            stable_r <= 1'b0;
        end else if (s2_r == stable_r) begin
            deb_r <= '0;
        end else if (deb_r >= CNT_W'(DEB - 1)) begin
            deb_r    <= '0;
            stable_r <= s2_r;
        end else begin
            deb_r <= deb_r + 1'b1;
        end
    end

    // ****************************************************************
    // Hold timer, saturating at the long threshold.
    // ****************************************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            hold_r  <= '0;
            o_short <= 1'b0;
            o_long  <= 1'b0;
        end else begin
            o_long  <= stable_r && hold_r == CNT_W'(LNG - 1);
            // A release between the thresholds yields no pulse.
            o_short <= !stable_r && hold_r != '0
                       && hold_r < CNT_W'(SHRT);
            if (!stable_r) begin
                hold_r <= '0;
            end else if (hold_r < CNT_W'(LNG)) begin
                hold_r <= hold_r + 1'b1;
            end
        end
    end

endmodule : pbw_press_timer

// ==== src/pbw_wake_qual.sv ====
`timescale 1ns/1ps
module pbw_wake_qual (
    input  wire logic                [5:0] i_req,
    input  wire logic                [5:0] i_en,
    input  wire pbw_pkg::pbw_state_t       i_state,
    input  wire logic                      i_deep,
    input  wire logic                      i_usb45,
    input  wire logic                      i_ac_loss,
    output logic                     [5:0] o_src
);
    import pbw_pkg::*;

    logic sleeping;
    logic s45;
    logic s5;

    assign sleeping = i_state != PBW_S0;
    assign s45      = i_state == PBW_S4 || i_state == PBW_S5;
    assign s5       = i_state == PBW_S5;

    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        assign o_src[i] = i_req[i] && i_en[i] && sleeping
            && !NEVER_MASK[i]
            && !(DEEP_MASK[i] && i_deep && s45)
            && !(ACL_MASK[i] && i_ac_loss)
            && !(OPT_MASK[i] && s45 && !i_usb45)
            && !(NET_MASK[i] && s5 && i_ac_loss && i_deep);
    end

endmodule : pbw_wake_qual

// ==== src/pbw_top.sv ====
// How it works
// - Short press powers on, wakes, or signals the OS for sleep.
// - Hold over six seconds forces soft-off from working or sleeping.
// - In S4 processor off and devices in D3 except wake logic.
// - Leaving S5 gives a cold boot pulse, never a resume.
// - Alarm wakes from S3, S4, S5; display sleeps after S3 wake.
// - Network wake from S5 after mains loss needs deep standby off.
// - Deep standby blocks serial-bus and infrared wake from S4 and S5.
// - Serial-bus wake from S3 always; S4 and S5 need firmware option.
// - PCIe wake pin wakes from S3, S4, S5; display sleeps after S3.
// - Infrared wakes from S3, S4, S5 within deep and AC-loss limits.
// - Wireless radio events never wake the system.
// - Serial-bus and infrared wake ignored right after mains return.
// - Software can command soft-off without any press.
// - Network magic frame request powers the system up.
`timescale 1ns/1ps
module pbw_top #(
    parameter int unsigned DEB  = pbw_pkg::DEB_CYC,
    parameter int unsigned SHRT = pbw_pkg::SHORT_CYC,
    parameter int unsigned LNG  = pbw_pkg::LONG_CYC
) (
    input  wire logic                i_ref_clk,
    input  wire logic                i_srst,
    input  wire logic                i_pwr_sw_n,
    input  wire logic                i_rtc_alarm,
    input  wire logic                i_network_wake,
    input  wire logic                i_usb_wake,
    input  wire logic                i_pcie_wake_n,
    input  wire logic                i_infrared_remote_receiver,
    input  wire logic                i_radio_event,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic         [31:0] paddr,
    input  wire logic         [31:0] pwdata,
    output logic              [31:0] prdata,
    output logic                     pready,
    output logic                     pslverr,
    output pbw_pkg::pbw_state_t      o_state,
    output logic                     o_cpu_pwr_en,
    output logic                     o_mem_pwr_en,
    output logic                     o_dev_d3,
    output logic                     o_cold_boot,
    output logic                     o_resume,
    output logic                     o_sleep_req,
    output logic                     o_display_sleep,
    output logic                     o_irq
);
    import pbw_pkg::*;

    pbw_state_t   state_r;
    pbw_state_t   state_nxt;
    logic         sh_press;
    logic         lg_press;
    logic   [5:0] pin_s1_r;
    logic   [5:0] pin_s2_r;
    logic   [5:0] wake_req;
    logic   [5:0] wake_src;
    logic         wake_any;
    logic   [2:0] ctrl_r;
    logic   [5:0] wen_r;
    logic   [2:0] istat_r;
    logic   [2:0] imask_r;
    logic   [2:0] irq_ev;
    logic         ac_loss_r;
    logic         wr_acc;
    logic         rd_acc;
    logic   [7:0] adr;
    logic         adr_ok;
    logic         cmd_vld;
    pbw_state_t   cmd_tgt;

    // ****************************************************************
    // Switch timing and wake qualification
    // ****************************************************************
    pbw_press_timer #(.DEB(DEB), .SHRT(SHRT), .LNG(LNG)) u_press (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_sw_n    (i_pwr_sw_n),
        .o_short   (sh_press),
        .o_long    (lg_press)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pin_s1_r <= 6'h08;
            pin_s2_r <= 6'h08;
        end else begin
            pin_s1_r <= {i_radio_event, i_infrared_remote_receiver,
                         i_pcie_wake_n, i_usb_wake, i_network_wake,
                         i_rtc_alarm};
            pin_s2_r <= pin_s1_r;
        end
    end

    // The PCIe wake pin is active low; flip it after the synchroniser.
    assign wake_req = pin_s2_r ^ 6'h08;

    pbw_wake_qual u_wake (
        .i_req     (wake_req),
        .i_en      (wen_r),
        .i_state   (state_r),
        .i_deep    (ctrl_r[CTRL_DEEP]),
        .i_usb45   (ctrl_r[CTRL_USB45]),
        .i_ac_loss (ac_loss_r),
        .o_src     (wake_src)
    );
    assign wake_any = |wake_src;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign adr    = paddr[7:0];
    assign adr_ok = paddr[31:8] == '0 && (adr == REG_CTRL
                    || adr == REG_CMD || adr == REG_WEN
                    || adr == REG_STATE || adr == REG_ISTAT
                    || adr == REG_IMASK);
    assign pready = psel && penable;
    assign wr_acc = pready && pwrite && adr_ok;
    assign rd_acc = pready && !pwrite && adr_ok;
    assign cmd_vld = wr_acc && adr == REG_CMD && pwdata[1:0] != 2'b00;
    assign cmd_tgt = pbw_state_t'({1'b0, pwdata[1:0]});

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !adr_ok;
            if (adr == REG_CTRL) begin
                prdata <= {30'h0, ctrl_r[1:0]};
            end else if (adr == REG_WEN) begin
                prdata <= {26'h0, wen_r};
            end else if (adr == REG_STATE) begin
                prdata <= {26'h0, o_display_sleep, ac_loss_r, 1'b0,
                           state_r};
            end else if (adr == REG_ISTAT) begin
                prdata <= {29'h0, istat_r};
            end else if (adr == REG_IMASK) begin
                prdata <= {29'h0, imask_r};
            end else begin
                prdata <= '0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_r  <= '0;
            wen_r   <= WEN_RST;
            imask_r <= '0;
        end else if (wr_acc) begin
            if (adr == REG_CTRL) begin
                ctrl_r <= pwdata[2:0];
            end else if (adr == REG_WEN) begin
                wen_r <= pwdata[5:0];
            end else if (adr == REG_IMASK) begin
                imask_r <= pwdata[2:0];
            end
        end else begin
            ctrl_r[CTRL_DISP] <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupts: an event in the clearing read cycle is kept.
    // ****************************************************************
    assign irq_ev[IRQ_SLEEP] = o_sleep_req;
    assign irq_ev[IRQ_FORCE] = lg_press && state_r != PBW_S5;
    assign irq_ev[IRQ_WAKE]  = state_r != PBW_S0 && state_nxt == PBW_S0;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            istat_r <= '0;
        end else begin
            istat_r <= (rd_acc && adr == REG_ISTAT ? 3'h0 : istat_r)
                       | irq_ev;
        end
    end
    assign o_irq = |(istat_r & imask_r);

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PBW_S0: begin
                if (lg_press) begin
                    state_nxt = PBW_S5;
                end else if (cmd_vld) begin
                    state_nxt = cmd_tgt;
                end
            end
            PBW_S3, PBW_S4: begin
                if (lg_press) begin
                    state_nxt = PBW_S5;
                end else if (sh_press || wake_any) begin
                    state_nxt = PBW_S0;
                end
            end
            PBW_S5: begin
                if (sh_press || wake_any) begin
                    state_nxt = PBW_S0;
                end
            end
            default: begin
                state_nxt = PBW_S5;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_r     <= PBW_S5;
            o_cold_boot <= 1'b0;
            o_resume    <= 1'b0;
            o_sleep_req <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            o_cold_boot <= state_r == PBW_S5
                           && state_nxt == PBW_S0;
            o_resume    <= (state_r == PBW_S3 || state_r == PBW_S4)
                           && state_nxt == PBW_S0;
            // The OS decides whether a short press means sleep or off.
            o_sleep_req <= state_r == PBW_S0 && sh_press
                           && !lg_press;
        end
    end

    // Mains has just returned until the first full power-on.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ac_loss_r <= 1'b1;
        end else if (state_r == PBW_S0) begin
            ac_loss_r <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_display_sleep <= 1'b0;
        end else if (state_r == PBW_S3 && state_nxt == PBW_S0
                     && !sh_press && (wake_src & DISP_MASK) != '0) begin
            o_display_sleep <= 1'b1;
        end else if (ctrl_r[CTRL_DISP] || sh_press
                     || state_r != PBW_S0) begin
            o_display_sleep <= 1'b0;
        end
    end

    assign o_state      = state_r;
    assign o_cpu_pwr_en = state_r == PBW_S0;
    assign o_mem_pwr_en = state_r == PBW_S0
                          || state_r == PBW_S3;
    assign o_dev_d3     = state_r != PBW_S0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_leave_s5;
        state_r == PBW_S5 ##1 state_r == PBW_S0;
    endsequence

    long_off_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        lg_press && state_r != PBW_S5 |=> state_r == PBW_S5)
        else $error("long hold did not force soft-off");
    short_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        sh_press && !lg_press && state_r != PBW_S0 |=> state_r == PBW_S0)
        else $error("short press did not wake");
    cold_boot_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        s_leave_s5 |-> o_cold_boot && !o_resume)
        else $error("leaving soft-off gave no cold boot");
    mem_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        state_r == PBW_S3 |-> o_mem_pwr_en && !o_cpu_pwr_en && o_dev_d3)
        else $error("wrong power in S3");
    radio_never_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !wake_src[SRC_RADIO])
        else $error("radio treated as wake source");
    deep_block_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ctrl_r[CTRL_DEEP] && (state_r == PBW_S4 || state_r == PBW_S5)
        |-> !wake_src[SRC_USB] && !wake_src[SRC_IR])
        else $error("deep standby did not block wake");
    ac_loss_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ac_loss_r |-> !wake_src[SRC_USB] && !wake_src[SRC_IR])
        else $error("wake taken after mains return");
    sw_off_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        state_r == PBW_S0 && cmd_vld && pwdata[1:0] == 2'b11 && !lg_press
        |=> state_r == PBW_S5 ##1 (state_r == PBW_S5 || $past(wake_any)
        || $past(sh_press)))
        else $error("soft-off command ignored");
    wake_go_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        wake_any && !lg_press |=> state_r == PBW_S0 ##1 !ac_loss_r)
        else $error("qualified wake did not power on");
    disp_s3_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        $rose(o_display_sleep) |-> $past(state_r) == PBW_S3)
        else $error("display kept asleep after non-S3 wake");

endmodule : pbw_top

// ==== verif/pbw_panel_model.sv ====
`timescale 1ns/1ps
module pbw_panel_model #(
    parameter int unsigned DEB = 4
) (
    input  wire logic i_ref_clk,
    output logic      o_pwr_sw_n,
    output logic      o_rtc_alarm,
    output logic      o_network_wake,
    output logic      o_usb_wake,
    output logic      o_pcie_wake_n,
    output logic      o_infrared_remote_receiver,
    output logic      o_radio_event
);
    logic       sw_r;
    logic [5:0] src_r;

    initial begin
        sw_r  = 1'b1;
        src_r = 6'h00;
    end

    assign o_pwr_sw_n                 = sw_r;
    assign o_rtc_alarm                = src_r[0];
    assign o_network_wake             = src_r[1];
    assign o_usb_wake                 = src_r[2];
    assign o_pcie_wake_n              = ~src_r[3];
    assign o_infrared_remote_receiver = src_r[4];
    assign o_radio_event              = src_r[5];

    // Holds the switch down for the given cycles, then lets it settle.
    task automatic press(input int unsigned hold);
        @(posedge i_ref_clk);
        sw_r <= 1'b0;
        repeat (hold) @(posedge i_ref_clk);
        sw_r <= 1'b1;
        repeat (DEB + 12) @(posedge i_ref_clk);
    endtask : press

    // Raises one wake line for a few cycles, then drops it again.
    task automatic wake(input int unsigned k);
        @(posedge i_ref_clk);
        src_r[k] <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
        src_r[k] <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
    endtask : wake
endmodule : pbw_panel_model

// ==== verif/pbw_top_tb.sv ====
`timescale 1ns/1ps
module pbw_top_tb;
    import pbw_pkg::*;
    localparam int unsigned DEB = 4;
    logic        clk, srst, psel, penable, pwrite, err;
    logic        sw_n, rtc, net, usb, pcie_n, ir, radio;
    logic        pready, pslverr, cpu, mem, d3, cb, rs, slp, disp, irq;
    logic [31:0] paddr, pwdata, prdata, q;
    pbw_state_t  st_o;
    int          n_errors, samples_checked, n_cb, n_rs, n_slp;
    integer      seed;
    int unsigned k, s;

    pbw_top #(.DEB(DEB), .SHRT(40), .LNG(60)) i_pbw_top (
        .i_ref_clk(clk), .i_srst(srst), .i_pwr_sw_n(sw_n),
        .i_rtc_alarm(rtc), .i_network_wake(net), .i_usb_wake(usb),
        .i_pcie_wake_n(pcie_n), .i_infrared_remote_receiver(ir),
        .i_radio_event(radio), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .o_state(st_o), .o_cpu_pwr_en(cpu), .o_mem_pwr_en(mem),
        .o_dev_d3(d3), .o_cold_boot(cb), .o_resume(rs),
        .o_sleep_req(slp), .o_display_sleep(disp), .o_irq(irq));

    pbw_panel_model #(.DEB(DEB)) i_pbw_panel_model (
        .i_ref_clk(clk), .o_pwr_sw_n(sw_n), .o_rtc_alarm(rtc),
        .o_network_wake(net), .o_usb_wake(usb), .o_pcie_wake_n(pcie_n),
        .o_infrared_remote_receiver(ir), .o_radio_event(radio));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts the one-cycle pulses so that none is missed.
    always @(posedge clk) begin
        if (cb === 1'b1) n_cb <= n_cb + 1;
        if (rs === 1'b1) n_rs <= n_rs + 1;
        if (slp === 1'b1) n_slp <= n_slp + 1;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk("pready", 32'h1, {31'h0, pready});
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        // Lets the written value reach the outputs before they are read.
        repeat (2) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, q);
    endtask : rd

    task automatic st(input pbw_state_t e);
        int n;
        n = 0;
        while (st_o !== e && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk("state", {29'h0, e}, {29'h0, st_o});
    endtask : st

    function automatic int unsigned short_hold();
        return 5 + ($unsigned($random(seed)) % 30);
    endfunction : short_hold

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {n_errors, samples_checked, n_cb, n_rs, n_slp} = '0;
        seed = 38;
        srst = 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        st(PBW_S5);
        chk("mem_pwr", 32'h0, {31'h0, mem});
        chk("dev_d3", 32'h1, {31'h0, d3});
        rd(REG_WEN, {26'h0, WEN_RST});
        rd(8'h18, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        rd(REG_STATE, 32'h13);
        i_pbw_panel_model.wake(SRC_IR);
        st(PBW_S5);
        wr(REG_CTRL, 32'h1);
        i_pbw_panel_model.wake(SRC_NET);
        st(PBW_S5);
        wr(REG_CTRL, 32'h0);
        i_pbw_panel_model.wake(SRC_PCIE);
        st(PBW_S0);
        chk("cold_boot", 32'h1, n_cb);
        wr(REG_IMASK, 32'h1);
        rd(REG_IMASK, 32'h1);
        rd(REG_ISTAT, 32'h4);
        i_pbw_panel_model.press(short_hold());
        st(PBW_S0);
        chk("sleep_req", 32'h1, n_slp);
        chk("irq", 32'h1, {31'h0, irq});
        wr(REG_IMASK, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        rd(REG_ISTAT, 32'h1);
        wr(REG_IMASK, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(REG_CMD, 32'h1);
        st(PBW_S3);
        chk("cpu_pwr", 32'h0, {31'h0, cpu});
        chk("mem_pwr", 32'h1, {31'h0, mem});
        i_pbw_panel_model.wake(SRC_RADIO);
        st(PBW_S3);
        i_pbw_panel_model.wake(SRC_RTC);
        st(PBW_S0);
        chk("resume", 32'h1, n_rs);
        chk("disp", 32'h1, {31'h0, disp});
        wr(REG_CTRL, 32'h4);
        chk("disp", 32'h0, {31'h0, disp});
        wr(REG_CMD, 32'h2);
        st(PBW_S4);
        chk("dev_d3", 32'h1, {31'h0, d3});
        wr(REG_CTRL, 32'h1);
        i_pbw_panel_model.wake(SRC_USB);
        st(PBW_S4);
        wr(REG_CTRL, 32'h0);
        i_pbw_panel_model.wake(SRC_USB);
        st(PBW_S4);
        wr(REG_CTRL, 32'h2);
        rd(REG_CTRL, 32'h2);
        i_pbw_panel_model.wake(SRC_USB);
        st(PBW_S0);
        i_pbw_panel_model.press(50);
        st(PBW_S0);
        chk("sleep_req", 32'h1, n_slp);
        i_pbw_panel_model.press(80);
        st(PBW_S5);
        i_pbw_panel_model.press(short_hold());
        st(PBW_S0);
        chk("cold_boot", 32'h2, n_cb);
        wr(REG_CMD, 32'h3);
        st(PBW_S5);
        i_pbw_panel_model.wake(SRC_NET);
        st(PBW_S0);
        for (k = 0; k < 4; k++) begin
            s = $unsigned($random(seed)) % 5;
            wr(REG_CMD, 32'h1);
            st(PBW_S3);
            wr(REG_WEN, {26'h0, WEN_RST & ~(6'h01 << s)});
            i_pbw_panel_model.wake(s);
            st(PBW_S3);
            wr(REG_WEN, {26'h0, WEN_RST});
            i_pbw_panel_model.wake(s);
            st(PBW_S0);
        end
        complete_run();
    end
endmodule : pbw_top_tb
